/* File: inc/dswd_pkg.sv */
// constants, types and pin bundles for the serial word decoder
package dswd_pkg;

   // ==========================================================
   // word layout
   localparam int WORD_BITS = 24;   // bits per serial word
   localparam int BANK_BIT  = 23;   // bank (A or B) select
   localparam int RW_BIT    = 22;   // readback request
   localparam int ADDR_HI   = 19;   // channel address msb
   localparam int ADDR_LO   = 16;   // channel address lsb
   localparam int SEL_HI    = 15;   // register select msb
   localparam int SEL_LO    = 14;   // register select lsb
   localparam int PAY_HI    = 13;   // payload msb position
   localparam int HDR_LO    = 14;   // low bit of echoed header
   localparam int DATA_MAX  = 14;   // widest payload of the family
   localparam int ADDR_W    = 4;    // address field width
   localparam int CNT_W     = 6;    // serial clock counter width

   localparam logic [CNT_W-1:0] CNT_WORD = 6'h18;  // 24 clocks
   localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3f;  // saturation
   localparam logic [CNT_W-1:0] CNT_RST  = 6'h00;

   // ==========================================================
   // reset values of the per-channel registers, word registers and pin synchroniser
   localparam logic [13:0] CODE_RST_14   = 14'h0000;
   localparam logic [11:0] CODE_RST_12   = 12'h000;
   localparam logic [13:0] OFFSET_RST_14 = 14'h2000;  // midpoint
   localparam logic [11:0] OFFSET_RST_12 = 12'h800;   // midpoint
   localparam logic [13:0] GAIN_RST_14   = 14'h3ffe;  // unity
   localparam logic [11:0] GAIN_RST_12   = 12'hffe;   // unity
   localparam logic [WORD_BITS-1:0] WORD_RST = 24'h000000;
   localparam logic [4:0] PIN_SYNC_RST = 5'h04;  // frame sync idles high

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      SEL_SFR    = 2'h0,
      SEL_GAIN   = 2'h1,
      SEL_OFFSET = 2'h2,
      SEL_CODE   = 2'h3
   } dswd_sel_t;

   typedef enum logic [2:0] {
      ST_SLEEP = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } dswd_state_t;

   // serial pins coming from the host
   typedef struct packed {
      logic sync_n;
      logic sclk;
      logic din;
   } dswd_pins_t;

   // one decoded register write
   typedef struct packed {
      logic                bank;
      dswd_sel_t           sel;
      logic [ADDR_W-1:0]   chan;
      logic [DATA_MAX-1:0] data;
   } dswd_wr_t;

endpackage : dswd_pkg

/* File: hdl/dswd_sync2.sv */
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module dswd_sync2 #(
   parameter int             WIDTH = 5,
   parameter logic [WIDTH-1:0] RST = '0
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q   <= RST;
         sync_out <= RST;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : dswd_sync2

/* File: hdl/dswd_decoder.sv */
// serial input word decoder with per-channel code, offset and gain storage
`timescale 1ns/1ps
// Overview of operation
// [RQ1] select field routes code, offset, gain, special
// [RQ2] fourteen bit internal payload path variant
// [RQ3] twelve bit internal payload path variant
// [RQ4] write only addressed channel's chosen register
// [RQ5] input code is straight unsigned binary
// [RQ6] offset is offset binary, midpoint means zero
// [RQ7] gain linear, least significant bit zero
// [RQ8] shift interface active when select pin high
// [RQ9] interface wakes on frame sync falling edge
// [RQ10] host uses three or four wires
// [RQ11] chain pin picks standalone or daisy chain
// [RQ12] data output carries shifted-out chain data
// [RQ13] 24-bit word, msb first, fixed fields
// [RQ14] four address bits, payload bits 13:0
// [RQ15] twelve bit payload 13:2, low two ignored
// [RQ16] select pin low: two-wire slave, no clock
// [RQ17] bank bit picks A/B only in toggle
// [RQ18] short frame is bad and discarded
// [RQ19] read bit arms readback on next frame
// [RQ20] channel count and resolution are parameters
module dswd_decoder
   import dswd_pkg::*;
#(
   parameter int NCH = 16,   // 16 or 8 channels
   parameter int DW  = 14    // 14 or 12 bit resolution
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                iface_sel_pin,
   input  wire logic                chain_enable_pin,
   input  wire logic                toggle_mode_en,
   input  wire dswd_pkg::dswd_pins_t spi_pins,
   output logic                     sdo_pin,
   output logic                     iface_awake,
   output logic                     wr_pulse,
   output dswd_pkg::dswd_wr_t       wr_word,
   output logic                     bad_frame
);
   import dswd_pkg::*;

   // ==========================================================
   // derived constants
   localparam logic [DW-1:0] CODE_RST   =
      (DW == 12) ? DW'(CODE_RST_12) : DW'(CODE_RST_14);
   localparam logic [DW-1:0] OFFSET_RST =
      (DW == 12) ? DW'(OFFSET_RST_12) : DW'(OFFSET_RST_14);
   localparam logic [DW-1:0] GAIN_RST   =
      (DW == 12) ? DW'(GAIN_RST_12) : DW'(GAIN_RST_14);
   localparam int ALIGN = DATA_MAX - DW;  // zero bits below payload

   // ==========================================================
   // pin synchronisation and edge detection
   logic [4:0]    pin_s;
   logic          sync_n_s;
   logic          sclk_s;
   logic          din_s;
   logic          chain_s;
   logic          spi_mode;
   logic          sync_prev_q;
   logic          sclk_prev_q;
   logic          sync_fall;
   logic          sync_rise;
   logic          sclk_rise;
   logic          sclk_fall;

   dswd_sync2 #(.WIDTH(5), .RST(PIN_SYNC_RST)) u_sync (
      .clk      (clk),
      .rstn     (rstn),
      .async_in ({iface_sel_pin, chain_enable_pin, spi_pins}),
      .sync_out (pin_s)
   );

   // pin levels after the second stage only
   assign spi_mode = pin_s[4];
   assign chain_s  = pin_s[3];
   assign sync_n_s = pin_s[2];
   assign sclk_s   = pin_s[1];
   assign din_s    = pin_s[0];

   // previous levels for edge finding
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         sync_prev_q <= sync_n_s;
         sclk_prev_q <= sclk_s;
      end
   end

   assign sync_fall = sync_prev_q & ~sync_n_s;
   assign sync_rise = ~sync_prev_q & sync_n_s;
   assign sclk_rise = ~sclk_prev_q & sclk_s;
   assign sclk_fall = sclk_prev_q & ~sclk_s;

   // ==========================================================
   // frame state machine
   dswd_state_t      state_q;
   logic [CNT_W-1:0] cnt_q;
   logic             in_frame;
   logic             frame_end;
   logic             frame_good;

   assign in_frame   = (state_q == ST_SHIFT) || (state_q == ST_DONE);
   assign frame_end  = in_frame & sync_rise & spi_mode;
   assign frame_good = frame_end & (cnt_q >= CNT_WORD);  // RQ18
   assign iface_awake = in_frame;

   // sleeps until a frame opens; standalone stops after one word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_SLEEP;
      end else if (!spi_mode) begin
         state_q <= ST_SLEEP;  // RQ8 RQ16
      end else begin
         case (state_q)
            ST_SLEEP: begin
               if (sync_fall) state_q <= ST_SHIFT;  // RQ9
            end
            ST_SHIFT: begin
               if (sync_rise) begin
                  state_q <= ST_SLEEP;
               end else if (!chain_s && sclk_fall &&
                            cnt_q == CNT_WORD - 6'h01) begin
                  state_q <= ST_DONE;  // RQ11
               end
            end
            ST_DONE: begin
               if (sync_rise) state_q <= ST_SLEEP;
            end
            default: state_q <= ST_SLEEP;
         endcase
      end
   end

   // serial clock counter, saturating so long chains do not wrap
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= CNT_RST;
      end else if (state_q == ST_SLEEP && sync_fall) begin
         cnt_q <= CNT_RST;
      end else if (state_q == ST_SHIFT && sclk_fall &&
                   cnt_q != CNT_MAX) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // ==========================================================
   // shift register and data output
   logic [WORD_BITS-1:0] sr_q;
   logic [WORD_BITS-1:0] rb_word_q;
   logic                 rb_pend_q;
   logic                 sdo_q;
   logic                 rb_load;

   assign rb_load = (state_q == ST_SLEEP) & sync_fall & spi_mode
                    & rb_pend_q;

   // input sampled on the falling serial clock, msb first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sr_q <= WORD_RST;
      end else if (rb_load) begin
         sr_q <= rb_word_q;  // RQ19
      end else if (state_q == ST_SHIFT && sclk_fall) begin
         sr_q <= {sr_q[WORD_BITS-2:0], din_s};  // RQ13
      end
   end

   // output changes on the rising serial clock; in daisy chain the
   // 24-bit delay makes the previous word ripple to the next part
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdo_q <= 1'b0;
      end else if (rb_load) begin
         sdo_q <= rb_word_q[WORD_BITS-1];  // RQ19
      end else if (state_q == ST_SHIFT && sclk_rise) begin
         sdo_q <= sr_q[WORD_BITS-1];  // RQ12
      end
   end

   assign sdo_pin = sdo_q;

   // ==========================================================
   // field extraction
   logic [ADDR_W-1:0] addr;
   dswd_sel_t         sel;
   logic [DW-1:0]     pay;
   logic              chan_ok;
   logic              bank;
   logic              is_read;

   assign addr    = sr_q[ADDR_HI:ADDR_LO];  // RQ13 RQ14
   assign sel     = dswd_sel_t'(sr_q[SEL_HI:SEL_LO]);  // RQ1
   assign pay     = sr_q[PAY_HI -: DW];  // RQ2 RQ3 RQ15
   assign chan_ok = (32'(addr) < NCH);  // RQ20
   assign bank    = toggle_mode_en & sr_q[BANK_BIT];  // RQ17
   assign is_read = sr_q[RW_BIT];

   // ==========================================================
   // per-channel registers
   logic [DW-1:0] code_a_q [NCH];
   logic [DW-1:0] code_b_q [NCH];
   logic [DW-1:0] offs_q   [NCH];
   logic [DW-1:0] gain_q   [NCH];
   logic          wr_en;

   assign wr_en = frame_good & ~is_read & chan_ok;

   // only the addressed channel and chosen register take the payload
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NCH; i++) begin
            code_a_q[i] <= CODE_RST;
            code_b_q[i] <= CODE_RST;
            offs_q[i]   <= OFFSET_RST;
            gain_q[i]   <= GAIN_RST;
         end
      end else if (wr_en) begin
         case (sel)
            SEL_CODE: begin
               if (bank) code_b_q[addr] <= pay;  // RQ4 RQ5
               else      code_a_q[addr] <= pay;  // RQ4 RQ5
            end
            SEL_OFFSET: offs_q[addr] <= pay;  // RQ4 RQ6
            SEL_GAIN:   gain_q[addr] <= {pay[DW-1:1], 1'b0};  // RQ4 RQ7
            default: ;
         endcase
      end
   end

   // ==========================================================
   // readback arming; special registers live elsewhere, read as zero
   logic [DW-1:0]       rb_data;
   logic [DATA_MAX-1:0] rb_al;

   always_comb begin
      rb_data = '0;
      if (chan_ok) begin
         case (sel)
            SEL_CODE:   rb_data = bank ? code_b_q[addr] : code_a_q[addr];
            SEL_OFFSET: rb_data = offs_q[addr];
            SEL_GAIN:   rb_data = gain_q[addr];
            default:    rb_data = '0;
         endcase
      end
   end

   assign rb_al = DATA_MAX'(rb_data) << ALIGN;

   // the arming of a new read wins over the clear by a frame start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rb_pend_q <= 1'b0;
         rb_word_q <= WORD_RST;
      end else if (frame_good && is_read) begin
         rb_pend_q <= 1'b1;  // RQ19
         rb_word_q <= {sr_q[WORD_BITS-1:HDR_LO], rb_al};
      end else if (rb_load) begin
         rb_pend_q <= 1'b0;
      end
   end

   // ==========================================================
   // decoded write and bad frame outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_pulse  <= 1'b0;
         wr_word   <= '0;
         bad_frame <= 1'b0;
      end else begin
         wr_pulse  <= frame_good & ~is_read & (chan_ok | sel == SEL_SFR);
         bad_frame <= frame_end & ~frame_good;  // RQ18
         if (frame_good) begin
            wr_word.bank <= bank;
            wr_word.sel  <= sel;  // RQ1
            wr_word.chan <= addr;
            wr_word.data <= (sel == SEL_GAIN) ?
                            DATA_MAX'({pay[DW-1:1], 1'b0}) :
                            DATA_MAX'(pay);
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_bad_frame_drop: assert property (   // RQ18
      frame_end && cnt_q < CNT_WORD |=> bad_frame && !wr_pulse)
      else $error("short frame was not discarded");
   a_sleep_no_sync: assert property (   // RQ9
      state_q == ST_SLEEP && !sync_fall |=> state_q == ST_SLEEP)
      else $error("interface woke without frame sync edge");
   a_two_wire_quiet: assert property (   // RQ16
      !spi_mode |=> state_q == ST_SLEEP && $stable(sdo_q))
      else $error("serial logic active in two-wire mode");
   a_standalone_cap: assert property (   // RQ11
      state_q == ST_DONE |-> cnt_q == CNT_WORD && !chain_s &&
      ($past(state_q) != ST_DONE || $stable(sr_q)))
      else $error("standalone word not capped at 24 clocks");
   a_select_route: assert property (   // RQ1
      frame_good && !is_read |=> wr_word.sel == $past(sel) &&
      wr_word.chan == $past(addr))
      else $error("write routed to wrong register");
   a_chan_bound: assert property (   // RQ4
      wr_pulse && wr_word.sel != SEL_SFR |-> 32'(wr_word.chan) < NCH)
      else $error("write to channel beyond count");
   a_gain_lsb: assert property (   // RQ7
      wr_pulse && wr_word.sel == SEL_GAIN |-> wr_word.data[0] == 1'b0)
      else $error("gain lsb not zero");
   a_payload_field: assert property (   // RQ15
      frame_good && !is_read |=> wr_word.data == DATA_MAX'($past(pay)) ||
      wr_word.sel == SEL_GAIN)
      else $error("payload taken from wrong bits");
   a_bank_default: assert property (   // RQ17
      frame_good && !toggle_mode_en |=> !wr_word.bank)
      else $error("bank B chosen without toggle mode");
   a_daisy_ripple: assert property (   // RQ12
      state_q == ST_SHIFT && sclk_rise && !rb_load |=>
      sdo_q == $past(sr_q[WORD_BITS-1]))
      else $error("data output not following shift register");
   a_readback_load: assert property (   // RQ19
      rb_load |=> sr_q == $past(rb_word_q) && !rb_pend_q)
      else $error("readback word not loaded at frame start");

   c_good_write: cover property (wr_pulse && wr_word.sel == SEL_CODE);
   c_bad_frame:  cover property (bad_frame);
   c_readback:   cover property (rb_load);
   c_daisy_long: cover property (frame_good && chain_s &&
                                 cnt_q > CNT_WORD);

endmodule : dswd_decoder

/* File: bench/dswd_host.sv */
// host serial port model driving frame sync, clock and data
`timescale 1ns/1ps
module dswd_host
   import dswd_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     sdo_pin,
   output dswd_pkg::dswd_pins_t pins
);
   import dswd_pkg::*;

   // ==========================================================
   // idle: sync high, clock idles high so the first readback bit
   // is already on the data output when the first fall comes
   initial pins = '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0};

   // ==========================================================
   // one frame of n bits from the low end of w, msb first; the
   // output line is sampled just before each clock fall
   task automatic xfer(input logic [47:0] w, input int n,
                       output logic [47:0] got);
      got = '0;
      @(posedge clk);
      pins.sync_n <= 1'b0;
      pins.din    <= w[n-1];
      repeat (3) @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         repeat (4) @(posedge clk);
         @(negedge clk);
         got = {got[46:0], sdo_pin};
         @(posedge clk);
         pins.sclk <= 1'b0;
         repeat (3) @(posedge clk);
         pins.sclk <= 1'b1;
         // after the last bit the line toggles, never keeps old data
         pins.din  <= (i > 0) ? w[i-1] : ~w[i];
      end
      // a short n raises sync early on purpose
      repeat (4) @(posedge clk);
      pins.sync_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : xfer

endmodule : dswd_host

/* File: bench/tb_top.sv */
// self-checking bench for the serial word decoder
`timescale 1ns/1ps
module tb_top;
   import dswd_pkg::*;

   // ==========================================================
   // signals and bookkeeping
   logic        clk      = 1'b0;
   logic        rstn     = 1'b0;
   logic        sel_pin  = 1'b1;
   logic        chain    = 1'b0;
   logic        tog      = 1'b0;
   dswd_pins_t  pins;
   logic        sdo;
   logic        awake;
   logic        wr_p;
   logic        bad;
   dswd_wr_t    wr_w;
   dswd_wr_t    wr_w12;
   int          n_aw        = 0;
   int          num_errors  = 0;
   int          comparisons = 0;
   int          n_wr        = 0;
   int          n_bad       = 0;
   int          seed        = 32'ha5c4588e;
   logic [13:0] m_reg [4][16];   // model registers by select code
   logic [47:0] got;

   always #12.5 clk = ~clk;

   dswd_decoder #(.NCH(16), .DW(14)) dut (
      .clk(clk), .rstn(rstn), .iface_sel_pin(sel_pin),
      .chain_enable_pin(chain), .toggle_mode_en(tog),
      .spi_pins(pins), .sdo_pin(sdo), .iface_awake(awake),
      .wr_pulse(wr_p), .wr_word(wr_w), .bad_frame(bad));

   // 12-bit variant on the same pins; its payload sits at bits 13:2
   dswd_decoder #(.NCH(16), .DW(12)) dut12 (
      .clk(clk), .rstn(rstn), .iface_sel_pin(sel_pin),
      .chain_enable_pin(chain), .toggle_mode_en(tog),
      .spi_pins(pins), .sdo_pin(), .iface_awake(),
      .wr_pulse(), .wr_word(wr_w12), .bad_frame());

   dswd_host host (.clk(clk), .sdo_pin(sdo), .pins(pins));

   // ==========================================================
   // count result pulses and awake cycles; the write and bad frame pulses stand for one cycle only
   always @(posedge clk) begin
      if (wr_p === 1'b1) n_wr++;
      if (bad === 1'b1) n_bad++;
      if (awake === 1'b1) n_aw++;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // one frame, then pulse counts and the decoded write against
   // the model; the model skips special register writes and bank B code writes
   task automatic frame(input logic [47:0] w, input int n,
                        input logic exp_wr, input logic exp_bad);
      int       w0;
      int       b0;
      int       a0;
      dswd_wr_t e;
      logic [13:0] d12;
      w0 = n_wr;
      b0 = n_bad;
      a0 = n_aw;
      host.xfer(w, n, got);
      // awake from three clocks after the sync fall to three after
      // the sync rise, which the host places 8n+7 clocks apart
      chk("awake cycles", sel_pin ? 32'(8 * n + 7) : 32'h0,
          32'(n_aw - a0));
      chk("write pulses", 32'(exp_wr), 32'(n_wr - w0));
      chk("bad frames", 32'(exp_bad), 32'(n_bad - b0));
      if (exp_wr) begin
         e.sel  = dswd_sel_t'(w[15:14]);
         e.bank = tog & w[23];
         e.chan = w[19:16];
         e.data = w[13:0];
         if (e.sel == SEL_GAIN) e.data[0] = 1'b0;
         chk("write word", 32'(e), 32'(wr_w));
         d12 = {2'h0, w[13:2]};
         if (e.sel == SEL_GAIN) d12[0] = 1'b0;
         chk("write data 12-bit", 32'(d12), 32'(wr_w12.data));
         if (e.sel != SEL_SFR && !(e.bank && e.sel == SEL_CODE))
            m_reg[e.sel][e.chan] = e.data;
      end
   endtask : frame

   // read request, then a no-op frame that clocks the data out
   task automatic rd(input logic [3:0] ch, input logic [1:0] s);
      logic [23:0] rw;
      rw = {4'h4, ch, s, 14'h0};
      frame(48'(rw), 24, 1'b0, 1'b0);
      frame(48'h0, 24, 1'b1, 1'b0);
      chk("readback", {8'h0, rw[23:14], m_reg[s][ch]},
          {8'h0, got[23:0]});
   endtask : rd

   // ==========================================================
   // hang guard, well beyond the longest expected run
   initial begin
      #2ms;
      num_errors++;
      give_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [23:0] w;
      logic [23:0] w1;
      for (int c = 0; c < 16; c++) begin
         m_reg[0][c] = 14'h0;
         m_reg[1][c] = GAIN_RST_14;
         m_reg[2][c] = OFFSET_RST_14;
         m_reg[3][c] = CODE_RST_14;
      end
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      chk("word after reset", 32'h0, 32'(wr_w));
      chk("awake after reset", 32'h0, 32'(awake));
      $display("test reset done");
      // reset values of gain, offset and code through readback
      for (int s = 1; s < 4; s++) rd(4'(s * 5), 2'(s));
      $display("test defaults done");
      // every select code, random channel, payload and bank bit
      for (int k = 0; k < 12; k++) begin
         w = $random(seed);
         w[22:20] = 3'h0;
         w[15:14] = 2'(k);
         if (k == 3) w[13:0] = 14'h3fff;
         frame(48'(w), 24, 1'b1, 1'b0);
         rd(w[19:16], w[15:14]);
      end
      $display("test writes done");
      tog <= 1'b1;
      frame(48'h83c123, 24, 1'b1, 1'b0);
      tog <= 1'b0;
      $display("test toggle done");
      frame(48'h3fc, 10, 1'b0, 1'b1);
      rd(4'h2, 2'h3);
      $display("test short frame done");
      sel_pin <= 1'b0;
      repeat (4) @(posedge clk);
      frame(48'h0fffff, 24, 1'b0, 1'b0);
      chk("awake in two-wire mode", 32'h0, 32'(awake));
      sel_pin <= 1'b1;
      repeat (4) @(posedge clk);
      $display("test interface select done");
      chain <= 1'b1;
      repeat (4) @(posedge clk);
      w1 = $random(seed);
      w = $random(seed);
      w[22:20] = 3'h0;
      frame({w1, w}, 48, 1'b1, 1'b0);
      chk("chain output", {8'h0, w1}, {8'h0, got[23:0]});
      chain <= 1'b0;
      $display("test daisy chain done");
      give_verdict();
   end

endmodule : tb_top
